/* File: include/fxau_pkg.sv */
// shared constants, operation codes and carriers for the fixed-point unit
package fxau_pkg;

   // apb register byte offsets
   localparam logic [11:0] FXAU_CTRL_OFS = 12'h000;
   localparam logic [11:0] FXAU_STATUS_OFS = 12'h004;
   localparam logic [11:0] FXAU_COUNT_OFS = 12'h008;

   // control register layout and reset value
   localparam int FXAU_CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] FXAU_CTRL_RESET = 32'h0000_0001;

   // status register field positions
   localparam int FXAU_ST_CC_LSB = 0;
   localparam int FXAU_ST_PROT_BIT = 2;
   localparam int FXAU_ST_ADDR_BIT = 3;
   localparam int FXAU_ST_SPEC_BIT = 4;
   localparam int FXAU_ST_OVF_BIT = 5;
   localparam int FXAU_ST_BUSY_BIT = 6;

   // condition code values for signed results
   localparam logic [1:0] FXAU_CC_ZERO = 2'h0;
   localparam logic [1:0] FXAU_CC_NEG = 2'h1;
   localparam logic [1:0] FXAU_CC_POS = 2'h2;
   localparam logic [1:0] FXAU_CC_OVF = 2'h3;

   // storage word step for load multiple
   localparam logic [31:0] FXAU_WORD_STEP = 32'h0000_0004;

   typedef enum logic [3:0] {
      load_and_test,
      load_complement,
      load_positive,
      load_negative,
      load_multiple,
      add_register,
      add_halfword,
      unsigned_add_register,
      unsigned_add_storage,
      subtract_register,
      subtract_halfword,
      unsigned_subtract
   } fxau_op_t;

   // decoded operation as presented by the sequencer
   typedef struct packed {
      fxau_op_t op;
      logic [3:0] r1;
      logic [3:0] r3;
      logic [31:0] opnd1;
      logic [31:0] opnd2;
      logic [31:0] addr;
      logic from_storage;
      logic ovf_mask;
      logic prot_exc;
      logic addr_exc;
   } fxau_req_t;

   // one completion or register-write beat
   typedef struct packed {
      logic [31:0] result;
      logic [1:0] cc;
      logic cc_upd;
      logic wr_en;
      logic [3:0] wr_reg;
      logic last;
      logic ovf;
      logic ovf_irq;
      logic prot_exc;
      logic addr_exc;
      logic spec_exc;
   } fxau_rsp_t;

endpackage : fxau_pkg

/* File: verilog/fxau_adder.sv */
// 32-bit adder with sign carry and signed overflow
`timescale 1ns/1ps
`default_nettype none
module fxau_adder
(
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic cin,
   output logic [31:0] sum,
   output logic carry,
   output logic ovf
);
   logic [31:0] low;
   logic [1:0] top;

   // split at the sign bit so both carries are visible
   always_comb
   begin
      low = {1'b0, a[30:0]} + {1'b0, b[30:0]} + {31'h0000_0000, cin};
      top = {1'b0, a[31]} + {1'b0, b[31]} + {1'b0, low[31]};
      sum = {top[0], low[30:0]}; // wrapped sum, sign not corrected
      carry = top[1];
      ovf = top[1] ^ low[31]; // sign carry differs from numeric carry
   end
endmodule : fxau_adder
`default_nettype wire

/* File: verilog/fxau_apb.sv */
// apb register slave: control, last status and completion count
`timescale 1ns/1ps
`default_nettype none
module fxau_apb
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic busy,
   input wire logic done,
   input wire fxau_pkg::fxau_rsp_t last_rsp,
   output logic enable
);
   import fxau_pkg::*;

   logic [31:0] ctrl, next_ctrl;
   logic [6:0] status, next_status;
   logic [31:0] count, next_count;
   logic [31:0] next_prdata;
   logic mapped;
   logic wr;

   // zero wait states: read data is prepared during the setup cycle
   assign pready = 1'b1;
   assign mapped = (paddr[11:0] == FXAU_CTRL_OFS) ||
      (paddr[11:0] == FXAU_STATUS_OFS) || (paddr[11:0] == FXAU_COUNT_OFS);
   assign pslverr = psel & penable & ~mapped;
   assign wr = psel & penable & pwrite & mapped;
   assign enable = ctrl[FXAU_CTRL_ENABLE_BIT];

   // register next values; a completion beats a clearing write of count
   always_comb
   begin
      next_ctrl = ctrl;
      next_status = status;
      next_count = count;
      next_prdata = prdata;
      if (wr && paddr[11:0] == FXAU_CTRL_OFS)
         next_ctrl = {31'h0000_0000, pwdata[FXAU_CTRL_ENABLE_BIT]};
      if (wr && paddr[11:0] == FXAU_COUNT_OFS)
         next_count = 32'h0000_0000;
      if (done)
      begin
         next_count = 32'(count + 32'h0000_0001);
         next_status[FXAU_ST_CC_LSB +: 2] = last_rsp.cc;
         next_status[FXAU_ST_PROT_BIT] = last_rsp.prot_exc;
         next_status[FXAU_ST_ADDR_BIT] = last_rsp.addr_exc;
         next_status[FXAU_ST_SPEC_BIT] = last_rsp.spec_exc;
         next_status[FXAU_ST_OVF_BIT] = last_rsp.ovf;
      end
      next_status[FXAU_ST_BUSY_BIT] = busy;
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr[11:0])
            FXAU_CTRL_OFS: next_prdata = ctrl;
            FXAU_STATUS_OFS: next_prdata = {25'h000_0000, status};
            FXAU_COUNT_OFS: next_prdata = count;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= FXAU_CTRL_RESET;
         status <= 7'h00;
         count <= 32'h0000_0000;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         ctrl <= next_ctrl;
         status <= next_status;
         count <= next_count;
         prdata <= next_prdata;
      end
   end
endmodule : fxau_apb
`default_nettype wire

/* File: verilog/fxau_top.sv */
// fixed-point load, add and subtract execution datapath
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - load and test copies, codes sign
// - load complement writes negated operand
// - complementing max negative keeps it, code 3
// - overflow interrupts only when mask set
// - signed ops code zero, neg, pos, overflow
// - load positive writes absolute value, no code 1
// - load negative writes negated magnitude, codes 0/1
// - load multiple ascends, wraps 15 to 0
// - any field pair; equal means one word
// - load multiple keeps code and storage
// - full 32-bit add, carry-compare overflow
// - overflowed sum stays wrapped
// - halfword operand sign-extended first
// - subtract adds inverse plus one
// - logical code bits: carry, nonzero
// - logical ops never overflow-interrupt
// - add logical code encodes zero and carry
// - storage forms report storage exceptions
// - only first operand register written, except load multiple
module fxau_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   output logic req_ready,
   input wire fxau_pkg::fxau_req_t req,
   output logic mem_req_valid,
   output logic [31:0] mem_addr,
   input wire logic mem_rvalid,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_prot_exc,
   input wire logic mem_addr_exc,
   output logic rsp_valid,
   output var fxau_pkg::fxau_rsp_t rsp
);
   import fxau_pkg::*;

   typedef enum logic [1:0] {st_idle, st_lm_fetch} fxau_state_t;

   fxau_state_t state, next_state;
   logic [3:0] lm_reg, next_lm_reg;
   logic [3:0] lm_last, next_lm_last;
   logic [31:0] next_mem_addr;
   logic next_rsp_valid;
   fxau_rsp_t next_rsp;
   fxau_rsp_t alu_rsp;
   logic enable;
   logic take;
   logic [31:0] opnd2_ext;
   logic [31:0] add_a;
   logic [31:0] add_b;
   logic add_cin;
   logic [31:0] add_sum;
   logic add_carry;
   logic add_ovf;
   logic storage_form;
   logic halfword_form;
   logic spec_bad;

   // signed condition code from a result and its overflow
   function automatic logic [1:0] fxau_cc_signed(input logic [31:0] v,
      input logic ovf);
      if (ovf)
         return FXAU_CC_OVF;
      else if (v == 32'h0000_0000)
         return FXAU_CC_ZERO;
      else if (v[31])
         return FXAU_CC_NEG;
      else
         return FXAU_CC_POS;
   endfunction : fxau_cc_signed

   // true when a storage address is off its operand boundary
   function automatic logic fxau_misaligned(input logic [31:0] a,
      input logic half);
      if (half)
         return a[0];
      else
         return a[1:0] != 2'h0;
   endfunction : fxau_misaligned

   // negation request for the adder: zero plus inverse plus one
   function automatic logic [64:0] fxau_negate(input logic [31:0] v);
      return {32'h0000_0000, ~v, 1'b1};
   endfunction : fxau_negate

   // pass-through request for the adder: zero plus value, no carry
   function automatic logic [64:0] fxau_pass(input logic [31:0] v);
      return {32'h0000_0000, v, 1'b0};
   endfunction : fxau_pass

   fxau_apb u_apb
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .busy(state != st_idle),
      .done(rsp_valid & rsp.last),
      .last_rsp(rsp),
      .enable(enable)
   );

   fxau_adder u_adder
   (
      .a(add_a),
      .b(add_b),
      .cin(add_cin),
      .sum(add_sum),
      .carry(add_carry),
      .ovf(add_ovf)
   );

   // software can hold off new work; a running load multiple finishes
   assign req_ready = (state == st_idle) & enable;
   assign take = req_valid & req_ready;
   assign mem_req_valid = (state == st_lm_fetch);

   // operand shaping and storage-form decode
   always_comb
   begin
      halfword_form = (req.op == add_halfword) ||
         (req.op == subtract_halfword);
      if (halfword_form)
         opnd2_ext = {{16{req.opnd2[15]}}, req.opnd2[15:0]};
      else
         opnd2_ext = req.opnd2;
      unique case (req.op)
         add_halfword, subtract_halfword, unsigned_add_storage,
         load_multiple:
            storage_form = 1'b1;
         add_register, subtract_register, unsigned_subtract:
            storage_form = req.from_storage;
         default:
            storage_form = 1'b0;
      endcase
      spec_bad = fxau_misaligned(req.addr, halfword_form);
   end

   // adder operand selection; every single-register load form routes through the adder
   // so complementing the most negative value overflows by itself
   always_comb
   begin
      {add_a, add_b, add_cin} = fxau_pass(req.opnd2);
      unique case (req.op)
         load_complement:
            {add_a, add_b, add_cin} = fxau_negate(req.opnd2);
         load_positive:
            if (req.opnd2[31])
               {add_a, add_b, add_cin} = fxau_negate(req.opnd2);
         load_negative:
            // zero stays positive zero: negating zero yields zero
            if (!req.opnd2[31])
               {add_a, add_b, add_cin} = fxau_negate(req.opnd2);
         add_register, add_halfword, unsigned_add_register,
         unsigned_add_storage:
         begin
            add_a = req.opnd1;
            add_b = opnd2_ext;
            add_cin = 1'b0;
         end
         subtract_register, subtract_halfword, unsigned_subtract:
         begin
            add_a = req.opnd1;
            add_b = ~opnd2_ext; // inverse plus low-order one
            add_cin = 1'b1;
         end
         default:
            {add_a, add_b, add_cin} = fxau_pass(req.opnd2);
      endcase
   end

   // single-beat result, code and exception flags
   always_comb
   begin
      alu_rsp = '0;
      alu_rsp.result = add_sum;
      alu_rsp.wr_en = 1'b1;
      alu_rsp.wr_reg = req.r1; // only the first operand is replaced
      alu_rsp.last = 1'b1;
      alu_rsp.cc_upd = 1'b1;
      unique case (req.op)
         load_and_test, load_negative:
            alu_rsp.cc = fxau_cc_signed(add_sum, 1'b0);
         load_complement, load_positive, add_register, add_halfword,
         subtract_register, subtract_halfword:
         begin
            alu_rsp.cc = fxau_cc_signed(add_sum, add_ovf);
            alu_rsp.ovf = add_ovf;
            alu_rsp.ovf_irq = add_ovf & req.ovf_mask;
         end
         unsigned_add_register, unsigned_add_storage, unsigned_subtract:
            // no overflow interruption, only carry and zero in the code
            alu_rsp.cc = {add_carry, |add_sum};
         default:
         begin
            alu_rsp.wr_en = 1'b0;
            alu_rsp.cc_upd = 1'b0;
         end
      endcase
      // storage forms carry the fetch outcome; register forms never do
      if (storage_form)
      begin
         alu_rsp.prot_exc = req.prot_exc;
         alu_rsp.addr_exc = req.addr_exc;
         alu_rsp.spec_exc = spec_bad;
      end
      // a suppressed operation leaves register, code and mask alone
      if (alu_rsp.prot_exc | alu_rsp.addr_exc | alu_rsp.spec_exc)
      begin
         alu_rsp.wr_en = 1'b0;
         alu_rsp.cc_upd = 1'b0;
         alu_rsp.ovf = 1'b0;
         alu_rsp.ovf_irq = 1'b0;
      end
   end

   // sequencing: one beat for plain ops, one beat per word for load
   // multiple; the address arrives fully formed from the sequencer, with
   // zero base or index already counted as absent
   always_comb
   begin
      next_state = state;
      next_lm_reg = lm_reg;
      next_lm_last = lm_last;
      next_mem_addr = mem_addr;
      next_rsp_valid = 1'b0;
      next_rsp = rsp;
      unique case (state)
         st_idle:
            if (take)
            begin
               if (req.op == load_multiple)
               begin
                  next_rsp = '0;
                  if (spec_bad)
                  begin
                     next_rsp.spec_exc = 1'b1;
                     next_rsp.last = 1'b1;
                     next_rsp_valid = 1'b1;
                  end
                  else
                  begin
                     next_state = st_lm_fetch;
                     next_lm_reg = req.r1;
                     next_lm_last = req.r3;
                     next_mem_addr = req.addr;
                  end
               end
               else
               begin
                  next_rsp = alu_rsp; // all fields in one beat
                  next_rsp_valid = 1'b1;
               end
            end
         st_lm_fetch:
            if (mem_rvalid)
            begin
               // code never updated, storage only read
               next_rsp = '0;
               next_rsp_valid = 1'b1;
               if (mem_prot_exc || mem_addr_exc)
               begin
                  next_rsp.prot_exc = mem_prot_exc;
                  next_rsp.addr_exc = mem_addr_exc;
                  next_rsp.last = 1'b1;
                  next_state = st_idle;
               end
               else
               begin
                  next_rsp.result = mem_rdata;
                  next_rsp.wr_en = 1'b1;
                  next_rsp.wr_reg = lm_reg;
                  // equal fields end after exactly one word
                  next_rsp.last = (lm_reg == lm_last);
                  if (lm_reg == lm_last)
                     next_state = st_idle;
                  // four-bit counter wraps 15 to 0 on its own
                  next_lm_reg = 4'(lm_reg + 4'h1);
                  next_mem_addr = 32'(mem_addr + FXAU_WORD_STEP);
               end
            end
         default:
            next_state = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= st_idle;
         lm_reg <= 4'h0;
         lm_last <= 4'h0;
         mem_addr <= 32'h0000_0000;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end
      else
      begin
         state <= next_state;
         lm_reg <= next_lm_reg;
         lm_last <= next_lm_last;
         mem_addr <= next_mem_addr;
         rsp_valid <= next_rsp_valid;
         rsp <= next_rsp;
      end
   end
endmodule : fxau_top
`default_nettype wire

/* File: sim/fxau_properties.sv */
// assertion checker on the fixed-point unit ports
`timescale 1ns/1ps
`default_nettype none
module fxau_properties
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire fxau_pkg::fxau_req_t req,
   input wire logic mem_req_valid,
   input wire logic [31:0] mem_addr,
   input wire logic mem_rvalid,
   input wire logic rsp_valid,
   input wire fxau_pkg::fxau_rsp_t rsp
);
   import fxau_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // an operation taken, and a fetched word handed over
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_beat;
      mem_req_valid && mem_rvalid;
   endsequence
   AST_PLAIN_ANSWER: assert property (
      s_take ##0 req.op != load_multiple |=> rsp_valid)
      else $error("no answer after plain operation");
   AST_MASK_GATES: assert property (
      s_take ##0 !req.ovf_mask |=> !rsp.ovf_irq)
      else $error("overflow request with mask off");
   AST_LOGIC_NO_OVF: assert property (
      s_take ##0 req.op inside {unsigned_add_register,
      unsigned_add_storage, unsigned_subtract} |=> !rsp.ovf && !rsp.ovf_irq)
      else $error("logical operation flagged overflow");
   AST_POS_NO_NEG: assert property (
      s_take ##0 req.op == load_positive |=> rsp.cc != FXAU_CC_NEG)
      else $error("load positive gave code one");
   AST_NEG_CODES: assert property (
      s_take ##0 req.op == load_negative |=> !rsp.cc[1] && !rsp.ovf)
      else $error("load negative code out of range");
   AST_TEST_COPY: assert property (
      s_take ##0 req.op == load_and_test |=> rsp.result == $past(req.opnd2))
      else $error("load and test did not copy");
   AST_LM_START: assert property (
      s_take ##0 req.op == load_multiple && req.addr[1:0] == 2'h0
      |=> mem_req_valid && mem_addr == $past(req.addr))
      else $error("multiple load start address wrong");
   AST_LM_STEP: assert property (
      s_beat ##1 mem_req_valid |-> mem_addr == $past(mem_addr) + FXAU_WORD_STEP)
      else $error("multiple load address step wrong");
   AST_LM_KEEPS_CC: assert property (
      s_beat |=> rsp_valid && !rsp.cc_upd)
      else $error("multiple load beat missing or touched code");
   AST_BUSY_REFUSES: assert property (
      mem_req_valid |-> !req_ready)
      else $error("request accepted during multiple load");
endmodule : fxau_properties
`default_nettype wire

/* File: sim/fxau_mem_model.sv */
// storage responder for the multiple-load fetch port
`timescale 1ns/1ps
`default_nettype none
module fxau_mem_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req_valid,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] lat,
   input wire logic [31:0] err_addr,
   output logic mem_rvalid,
   output logic [31:0] mem_rdata,
   output logic mem_prot_exc,
   output logic mem_addr_exc
);
   logic [1:0] wait_cnt;
   logic [1:0] next_wait_cnt;
   // wait lat cycles per word; count restarts after each handed word
   always_comb
   begin
      next_wait_cnt = wait_cnt + 2'h1;
      if (!mem_req_valid || mem_rvalid)
         next_wait_cnt = 2'h0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wait_cnt <= 2'h0;
      else
         wait_cnt <= next_wait_cnt;
   end
   // read-only words; off a beat the lines show the inverse, not old data
   always_comb
   begin
      mem_rvalid = mem_req_valid && wait_cnt == lat;
      mem_rdata = mem_addr ^ 32'hc3a5_0f0f;
      if (!mem_rvalid)
         mem_rdata = ~mem_rdata;
      mem_prot_exc = mem_rvalid && mem_addr == err_addr && !lat[0];
      mem_addr_exc = mem_rvalid && mem_addr == err_addr && lat[0];
   end
endmodule : fxau_mem_model
`default_nettype wire

/* File: sim/fxau_tb.sv */
// self-checking bench for the fixed-point unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fxau_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic req_valid, req_ready, mem_req_valid, mem_rvalid, rsp_valid;
   logic mem_prot_exc, mem_addr_exc;
   logic [31:0] paddr, pwdata, prdata, mem_addr, mem_rdata, err_addr, rd;
   logic [1:0] lat;
   logic [31:0] ev [6] = '{32'h0, 32'h1, 32'hffff_ffff, 32'h8000_0000,
      32'h7fff_ffff, 32'h0000_8000};
   fxau_req_t req;
   fxau_rsp_t rsp, last_e;
   fxau_rsp_t expq[$];
   int errors, compares, done_ops, k;
   fxau_top fxau_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready, .req,
      .mem_req_valid, .mem_addr, .mem_rvalid, .mem_rdata, .mem_prot_exc,
      .mem_addr_exc, .rsp_valid, .rsp);
   fxau_mem_model fxau_mem_model_i (.pclk, .presetn, .mem_req_valid,
      .mem_addr, .lat, .err_addr, .mem_rvalid, .mem_rdata, .mem_prot_exc,
      .mem_addr_exc);
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (e !== g)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task test_done;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   // one apb transfer; read data and error land in rd and er
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= 32'(a);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n == 20)
      begin
         errors++;
         test_done();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // reference result from integer arithmetic, not from carry logic
   function automatic fxau_rsp_t model(input fxau_req_t q);
      fxau_rsp_t e;
      longint x, y, t;
      logic [31:0] b;
      logic hw, st, lg;
      e = '0;
      b = q.opnd2;
      hw = q.op inside {add_halfword, subtract_halfword};
      lg = q.op inside {unsigned_add_register, unsigned_add_storage,
         unsigned_subtract};
      st = hw || q.op == unsigned_add_storage || (q.from_storage &&
         q.op inside {add_register, subtract_register, unsigned_subtract});
      if (hw)
         b = {{16{b[15]}}, b[15:0]};
      x = $signed(q.opnd1);
      y = $signed(b);
      case (q.op)
         load_and_test: t = y;
         load_complement: t = -y;
         load_positive: t = y < 0 ? -y : y;
         load_negative: t = y > 0 ? -y : y;
         add_register, add_halfword: t = x + y;
         unsigned_subtract: t = {32'h0, q.opnd1} + {32'h0, ~b} + 1;
         unsigned_add_register, unsigned_add_storage:
            t = {32'h0, q.opnd1} + {32'h0, b};
         default: t = x - y;
      endcase
      e.result = t[31:0];
      if (lg)
         e.cc = {t[32], e.result != 0};
      else
         e.ovf = t > 64'sh7fff_ffff || t < -64'sh8000_0000;
      if (!lg)
         e.cc = e.ovf ? 2'h3 : e.result == 0 ? 2'h0 : {~e.result[31],
            e.result[31]};
      e.ovf_irq = e.ovf && q.ovf_mask;
      {e.cc_upd, e.wr_en, e.last} = 3'h7;
      e.wr_reg = q.r1;
      if (st)
         {e.prot_exc, e.addr_exc, e.spec_exc} = {q.prot_exc, q.addr_exc,
            hw ? q.addr[0] : q.addr[1:0] != 2'h0};
      // a suppressed operation still shows its code, but flags no update
      if (e.prot_exc || e.addr_exc || e.spec_exc)
         {e.cc_upd, e.wr_en, e.ovf, e.ovf_irq} = '0;
      return e;
   endfunction : model
   function automatic fxau_req_t mk(fxau_op_t op, logic [31:0] a, b);
      fxau_req_t q;
      q = $bits(fxau_req_t)'({$urandom, $urandom, $urandom, $urandom});
      q.op = op;
      q.opnd1 = a;
      q.opnd2 = b;
      q.addr[1:0] = $urandom % 8 == 0 ? 2'($urandom) : 2'h0;
      q.prot_exc = $urandom % 9 == 0;
      q.addr_exc = $urandom % 9 == 0;
      return q;
   endfunction : mk
   // wait for the next beat and compare it with the queue head
   task check_beat;
      fxau_rsp_t e, g;
      int n;
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (rsp_valid !== 1'b1 && n < 20);
      if (rsp_valid !== 1'b1)
      begin
         errors++;
         test_done();
      end
      e = expq.pop_front();
      last_e = e;
      g = rsp;
      if (!e.wr_en)
         {e.result, e.wr_reg, g.result, g.wr_reg} = '0;
      chk("rsp", 64'(e), 64'(g));
      done_ops += e.last;
   endtask : check_beat
   // offer an operation; the previous answer is checked meanwhile
   task issue(input fxau_req_t q);
      req <= q;
      req_valid <= 1'b1;
      if (expq.size() > 0)
         check_beat();
      else
         @(negedge pclk);
      chk("ready", 1, 64'(req_ready));
      @(posedge pclk);
      expq.push_back(model(q));
   endtask : issue
   task flush;
      req_valid <= 1'b0;
      check_beat();
      @(posedge pclk);
   endtask : flush
   task lm(input logic [3:0] r1, r3, input logic [31:0] a,
      input logic [1:0] l, input int bad);
      fxau_req_t q;
      fxau_rsp_t e;
      int n;
      q = mk(load_multiple, 0, 0);
      {q.r1, q.r3, q.addr} = {r1, r3, a}; // address fully formed
      lat <= l;
      err_addr <= a + 32'(4 * bad);
      req <= q;
      req_valid <= 1'b1;
      @(posedge pclk);
      req_valid <= 1'b0;
      n = ((r3 - r1) & 15) + 1;
      for (int i = 0; i < n; i++)
      begin
         e = '0;
         e.result = (a + 32'(4 * i)) ^ 32'hc3a5_0f0f;
         e.wr_reg = r1 + 4'(i);
         {e.wr_en, e.last} = {1'b1, i == n - 1};
         {e.prot_exc, e.addr_exc} = {i == bad && !l[0], i == bad && l[0]};
         e.spec_exc = a[1:0] != 2'h0;
         if (e.prot_exc || e.addr_exc || e.spec_exc)
            {e.wr_en, e.last, n} = {2'b01, 32'h0};
         expq.push_back(e);
         check_beat();
      end
      @(posedge pclk);
   endtask : lm
   initial
   begin
      {presetn, psel, penable, pwrite, req_valid, lat} = '0;
      {paddr, pwdata, req, errors, compares, done_ops} = '0;
      err_addr = '1;
      void'($urandom(6501));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, FXAU_CTRL_OFS, 0);
      chk("ctrl", FXAU_CTRL_RESET, rd);
      apb(1'b0, 12'h00c, 0);
      chk("unmapped", 1, {rd, er});
      for (k = 0; k < 432; k++)
         if (k / 36 != 4)
            issue(mk(fxau_op_t'(k / 36), ev[k % 36 / 6], ev[k % 6]));
      repeat (300)
      begin
         k = $urandom % 11;
         issue(mk(fxau_op_t'(k < 4 ? k : k + 1), $urandom, $urandom));
      end
      flush();
      apb(1'b0, FXAU_STATUS_OFS, 0);
      chk("status", {last_e.ovf, last_e.spec_exc, last_e.addr_exc,
         last_e.prot_exc, last_e.cc}, rd[5:0]);
      lm(4'h2, 4'h3, 32'h100, 2'h0, -1);
      lm(4'h5, 4'h5, 32'h204, 2'h2, -1);
      lm(4'h7, 4'h6, 32'h300, 2'h1, -1);
      lm(4'hf, 4'he, 32'h400, 2'h0, 5);
      lm(4'h3, 4'h9, 32'h500, 2'h1, 2);
      lm(4'h0, 4'h3, 32'h602, 2'h0, -1);
      apb(1'b0, FXAU_COUNT_OFS, 0);
      chk("count", done_ops, rd);
      apb(1'b1, FXAU_COUNT_OFS, 0);
      apb(1'b0, FXAU_COUNT_OFS, 0);
      chk("cleared", 0, rd);
      apb(1'b1, FXAU_CTRL_OFS, 0);
      req <= mk(add_register, 1, 1);
      req_valid <= 1'b1;
      repeat (3)
      begin
         @(negedge pclk);
         chk("refused", 0, {req_ready, rsp_valid});
      end
      @(posedge pclk);
      req_valid <= 1'b0;
      apb(1'b1, FXAU_CTRL_OFS, 1);
      issue(mk(subtract_register, ev[3], ev[3]));
      flush();
      test_done();
   end
   // cut a hang short
   initial
   begin
      repeat (60000) @(posedge pclk);
      errors++;
      test_done();
   end
endmodule : testbench
bind fxau_top fxau_properties fxau_properties_i (.pclk, .presetn, .req_valid,
   .req_ready, .req, .mem_req_valid, .mem_addr, .mem_rvalid, .rsp_valid, .rsp);
`default_nettype wire
